// ### wsw_regs.svh
/*
 * Register offsets, field positions, reset values, encodings and timing
 * counts for the watchdog, sleep and wake-up control block.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef WSW_REGS_SVH
`define WSW_REGS_SVH

// Word indexes on the register bus (byte address is four times these).
`define WSW_CPU_STATUS_IDX  4'h6
`define WSW_WAKE_CAUSE_IDX  4'h7

// Field positions within the cpu status register.
`define WSW_BIT_STKAV       5
`define WSW_BIT_GLOBAL_IRQ_DISABLE      4
`define WSW_BIT_TO          3
`define WSW_BIT_PD          2
`define WSW_BIT_POR         1
`define WSW_BIT_BOR         0
`define WSW_CPU_STATUS_RST  8'h3c

// Postscale select encodings and the divisors they choose.
`define WSW_PS_OFF          2'h0
`define WSW_PS_DIV64        2'h1
`define WSW_PS_DIV256       2'h2
`define WSW_PS_DIV1         2'h3
`define WSW_DIV_1           9'h001
`define WSW_DIV_64          9'h040
`define WSW_DIV_256         9'h100

// Oscillator mode encodings.
`define WSW_OSC_LF          2'h0
`define WSW_OSC_RC          2'h1
`define WSW_OSC_XT          2'h2
`define WSW_OSC_EC          2'h3

// Timing: oscillator period equals the 5 ns core clock.
`define WSW_CLK_NS          5
`define WSW_TOSC_NS         5
`define WSW_OST_TOSC        1024
`define WSW_OST_CYCLES      ((`WSW_OST_TOSC * `WSW_TOSC_NS + `WSW_CLK_NS - 1) / `WSW_CLK_NS)
`define WSW_TMR_OVF_TOSC    65536

`endif

// ### wsw_pkg.sv
/*
 * Types and shared decode functions of the watchdog sleep/wake block.
 * Assumes the constants header is on the include path.
 */
`include "wsw_regs.svh"

package wsw_pkg;

    // Control states, binary codes written out.
    typedef enum logic [2:0] {
        WSW_ST_RESET  = 3'h0,
        WSW_ST_PWRUP  = 3'h1,
        WSW_ST_RUN    = 3'h2,
        WSW_ST_SLEEP  = 3'h3,
        WSW_ST_OST    = 3'h4,
        WSW_ST_RESUME = 3'h5
    } wsw_state_type;

    // Interrupt sources, each already the AND of its enable and flag.
    typedef struct packed {
        logic int_pin;
        logic port_change;
        logic timer0_clk;
        logic capture;
        logic usart_sync_tx;
        logic usart_sync_rx;
        logic adc_done;
        logic spi_slave;
        logic i2c_slave_rx;
        logic other_periph;
    } wsw_wake_type;

    // Configuration word fields.
    typedef struct packed {
        logic [1:0] postscale;
        logic [1:0] osc_mode;
    } wsw_cfg_type;

    // Postscaler divisor for a select code (off counts as divide-by-1).
    function automatic logic [8:0] wsw_ps_div(input logic [1:0] sel);
        case (sel)
            `WSW_PS_DIV64:  wsw_ps_div = `WSW_DIV_64;
            `WSW_PS_DIV256: wsw_ps_div = `WSW_DIV_256;
            default:        wsw_ps_div = `WSW_DIV_1;
        endcase
    endfunction : wsw_ps_div

    // True for the crystal modes that need the start-up delay.
    function automatic logic wsw_is_crystal(input logic [1:0] mode);
        wsw_is_crystal = (mode == `WSW_OSC_XT) || (mode == `WSW_OSC_LF);
    endfunction : wsw_is_crystal

endpackage : wsw_pkg

// ### wsw_wdt_counter.sv
/*
 * Watchdog base counter with postscaler; pulses on a full period.
 * Assumes tick is synchronous to clk and div is at least one.
 */
`timescale 1ns/10ps

module wsw_wdt_counter #(
    parameter int BASE_W = 16,
    parameter int PS_W   = 9
) (
    input  wire logic              clk,          // Core clock.
    input  wire logic              rst,          // Synchronous reset, high.
    input  wire logic              clear,        // Clears counter and postscaler.
    input  wire logic              tick,         // Count enable for this edge.
    input  wire logic [PS_W-1:0]   div,          // Postscaler divisor.
    output logic                   overflow_reg  // One-cycle period pulse.
);
    import wsw_pkg::*;

    logic [BASE_W-1:0] base_reg;   // Base counter.
    logic [PS_W-1:0]   ps_reg;     // Postscaler count of base overflows.
    logic              base_wrap;  // Base counter is about to wrap.
    logic              ps_last;    // Postscaler holds its final count.

    // Refuse widths that cannot form a counter.
    if (BASE_W < 2 || PS_W < 1) begin : g_bad_width
        $error("wsw_wdt_counter: widths too small");
    end

    assign base_wrap = tick && (&base_reg);
    assign ps_last   = (ps_reg == div - 1'b1);

    // Base counter clears on request and otherwise counts ticks.
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            base_reg <= '0;
        end else if (tick) begin
            base_reg <= base_reg + 1'b1;
        end
    end

    // Postscaler counts base wraps and restarts after the last one.
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            ps_reg <= '0;
        end else if (base_wrap) begin
            ps_reg <= ps_last ? '0 : ps_reg + 1'b1;
        end
    end

    // A full period ends when the base wraps on the last postscale count.
    always_ff @(posedge clk) begin
        overflow_reg <= !(rst || clear) && base_wrap && ps_last;
    end

endmodule : wsw_wdt_counter

// ### wsw_watchdog_sleep_wake.sv
/*
 * Watchdog, power-up delay, sleep entry and wake-up control with the cpu
 * status register on an Avalon-MM slave with waitrequest.
 * Assumes the core issues sleep and clear as one-cycle pulses, that the
 * watchdog oscillator tick arrives already synchronous to clk, and that
 * interrupt sources arrive as enable AND flag.
 */
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "wsw_regs.svh"

module wsw_watchdog_sleep_wake #(
    parameter int TIMER_OVF_CYCLES = `WSW_TMR_OVF_TOSC
) (
    input  wire logic                 clk,                    // Core clock, 200 MHz.
    input  wire logic                 rst,                    // Synchronous reset, high.
    input  wire logic [3:0]           avs_address,            // Word index.
    input  wire logic                 avs_read,               // Read request.
    input  wire logic                 avs_write,              // Write request.
    input  wire logic [31:0]          avs_writedata,          // Write data.
    output logic [31:0]               avs_readdata,           // Read data.
    output logic                      avs_waitrequest,        // Stall, high.
    input  wire wsw_pkg::wsw_cfg_type cfg,                    // Configuration word.
    input  wire logic                 por_event,              // Power-on reset event.
    input  wire logic                 brownout_reset,         // Brown-out reset event.
    input  wire logic                 master_clear_pin_n,     // Master clear, low.
    input  wire logic                 wdt_rc_tick,            // Watchdog oscillator tick.
    input  wire logic                 sleep_instr,            // Sleep executes, pulse.
    input  wire logic                 watchdog_clear_instr,   // Clear executes, pulse.
    input  wire logic                 stack_avail,            // Stack space flag.
    input  wire wsw_pkg::wsw_wake_type wake_src,              // Enabled, flagged sources.
    output logic                      core_reset,             // Core held in reset.
    output logic                      core_asleep,            // Core clocks stopped.
    output logic                      osc_drive_en,           // Oscillator driver on.
    output logic                      io_hold,                // Pins keep their state.
    output logic                      prefetch_next,          // Fetch next word, pulse.
    output logic                      resume_exec,            // Wake resumes, pulse.
    output logic                      vector_branch,          // Branch after next, pulse.
    output logic                      timeout_flag,           // Timeout flag, low on timeout.
    output logic                      powerdown_flag,         // Powerdown flag, low after sleep.
    output logic                      global_irq_disable      // Global interrupt disable.
);
    import wsw_pkg::*;

    localparam int BASE_W = $clog2(TIMER_OVF_CYCLES);  // Base counter width.
    localparam int OST_N  = `WSW_OST_CYCLES;            // Start-up hold cycles.
    localparam int OST_W  = $clog2(OST_N);              // Start-up counter width.
    localparam logic [7:0] STATUS_RST = `WSW_CPU_STATUS_RST; // Status reset value.

    // Refuse overflow periods that are not a power of two.
    if (TIMER_OVF_CYCLES < 4 || (1 << BASE_W) != TIMER_OVF_CYCLES) begin : g_bad_ovf
        $error("wsw_watchdog_sleep_wake: overflow period must be a power of two");
    end

    wsw_state_type    state_reg;     // Control state.
    wsw_state_type    state_next;    // Next control state.
    logic [OST_W-1:0] ost_reg;       // Start-up delay count.
    logic [7:0]       status_reg;    // Cpu status register, assembled from its fields.
    logic             to_reg, pd_reg, por_reg, bor_reg, gd_reg, stk_reg; // Status fields, one owner each.
    logic [7:0]       cause_reg;     // Last wake or reset cause.
    logic             powerup_delay_timer_pend_reg; // Power-up delay owed after reset.
    logic             wait_reg;      // Waitrequest flip-flop.
    logic             timer_mode;    // Watchdog disabled, plain timer.
    logic             reset_evt;     // Any external reset event.
    logic             wake_irq;      // Qualifying interrupt present.
    logic             ovf;           // Counter period pulse.
    logic             wdt_reset;     // Watchdog timeout reset.
    logic             cnt_clear;     // Counter clear request.
    logic             cnt_tick;      // Counter count enable.
    logic [8:0]       cnt_div;       // Counter divisor.
    logic             in_run;        // Running state.
    logic             in_sleep;      // Sleep state.
    logic             bus_wr;        // Write commits this edge.
    logic             bus_rd;        // Read completes this edge.

    assign timer_mode = (cfg.postscale == `WSW_PS_OFF);
    assign in_run     = (state_reg == WSW_ST_RUN);
    assign in_sleep   = (state_reg == WSW_ST_SLEEP);
    assign reset_evt  = por_event || brownout_reset || !master_clear_pin_n;

    assign wake_irq = wake_src.int_pin || wake_src.port_change || wake_src.timer0_clk
                    || wake_src.capture || wake_src.usart_sync_tx || wake_src.usart_sync_rx
                    || wake_src.adc_done || wake_src.spi_slave || wake_src.i2c_slave_rx;

    assign wdt_reset = !timer_mode && ovf && (in_run || in_sleep);

    assign cnt_clear = (state_reg == WSW_ST_RESET)
                     || (in_run && (sleep_instr || watchdog_clear_instr))
                     || (in_sleep && wake_irq);

    // Tick source and divisor follow the active mode.
    always_comb begin
        cnt_tick = 1'b0;
        cnt_div  = wsw_ps_div(cfg.postscale);
        if (state_reg == WSW_ST_PWRUP) begin
            cnt_tick = wdt_rc_tick;
            cnt_div  = `WSW_DIV_1;
        end else if (timer_mode) begin
            cnt_tick = in_run;
        end else begin
            cnt_tick = wdt_rc_tick;
        end
    end

    wsw_wdt_counter #(
        .BASE_W (BASE_W),
        .PS_W   (9)
    ) u_counter (
        .clk          (clk),
        .rst          (rst),
        .clear        (cnt_clear),
        .tick         (cnt_tick),
        .div          (cnt_div),
        .overflow_reg (ovf)
    );

    // Next control state.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WSW_ST_RESET: begin
                if (!reset_evt) begin
                    state_next = powerup_delay_timer_pend_reg ? WSW_ST_PWRUP : WSW_ST_RUN;
                end
            end
            WSW_ST_PWRUP: begin
                if (ovf) begin
                    state_next = WSW_ST_RUN;
                end
            end
            WSW_ST_RUN: begin
                if (sleep_instr) begin
                    state_next = wake_irq ? WSW_ST_RESUME : WSW_ST_SLEEP;
                end
            end
            WSW_ST_SLEEP: begin
                if (wake_irq) begin
                    state_next = wsw_is_crystal(cfg.osc_mode) ? WSW_ST_OST : WSW_ST_RESUME;
                end
            end
            WSW_ST_OST: begin
                if (ost_reg == OST_W'(OST_N - 1)) begin
                    state_next = WSW_ST_RESUME;
                end
            end
            WSW_ST_RESUME: begin
                state_next = WSW_ST_RUN;
            end
            default: begin
                state_next = WSW_ST_RESET;
            end
        endcase
        if (reset_evt || wdt_reset) begin
            state_next = WSW_ST_RESET;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= WSW_ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Power-up delay is owed after rst, power-on or brown-out only.
    always_ff @(posedge clk) begin
        if (rst || por_event || brownout_reset) begin
            powerup_delay_timer_pend_reg <= 1'b1;
        end else if (state_reg == WSW_ST_PWRUP && ovf) begin
            powerup_delay_timer_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state_reg != WSW_ST_OST) begin
            ost_reg <= '0;
        end else begin
            ost_reg <= ost_reg + 1'b1;
        end
    end

    // Timeout and powerdown flags; any set wins over a clear.
    always_ff @(posedge clk) begin
        if (rst || por_event) begin
            to_reg <= 1'b1;
            pd_reg <= 1'b1;
        end else if (in_run && sleep_instr) begin
            to_reg <= 1'b1;
            pd_reg <= 1'b0;
        end else if (in_run && timer_mode && watchdog_clear_instr) begin
            to_reg <= 1'b1;
        end else if (ovf && (in_run || in_sleep)) begin
            to_reg <= 1'b0;
        end
    end

    // Reset cause bits: hardware clears, software writes one to set.
    always_ff @(posedge clk) begin
        if (rst) begin
            por_reg <= STATUS_RST[`WSW_BIT_POR];
            bor_reg <= STATUS_RST[`WSW_BIT_BOR];
        end else begin
            if (por_event) begin
                por_reg <= 1'b0;
            end else if (bus_wr && avs_address == `WSW_CPU_STATUS_IDX && avs_writedata[`WSW_BIT_POR]) begin
                por_reg <= 1'b1;
            end
            if (por_event || brownout_reset) begin
                bor_reg <= 1'b0;
            end else if (bus_wr && avs_address == `WSW_CPU_STATUS_IDX && avs_writedata[`WSW_BIT_BOR]) begin
                bor_reg <= 1'b1;
            end
        end
    end

    // Global disable is software writable; reset sets it.
    always_ff @(posedge clk) begin
        if (rst || state_reg == WSW_ST_RESET) begin
            gd_reg <= 1'b1;
        end else if (bus_wr && avs_address == `WSW_CPU_STATUS_IDX) begin
            gd_reg <= avs_writedata[`WSW_BIT_GLOBAL_IRQ_DISABLE];
        end
    end

    // Stack flag mirrors the core; the two top bits read as zero.
    always_ff @(posedge clk) begin
        stk_reg <= rst ? 1'b1 : stack_avail;
    end
    assign status_reg = {2'h0, stk_reg, gd_reg, to_reg, pd_reg, por_reg, bor_reg};

    // Cause register: bit0 reset event, bit1 watchdog, bit2 interrupt wake.
    always_ff @(posedge clk) begin
        if (rst) begin
            cause_reg <= 8'h00;
        end else if (reset_evt) begin
            cause_reg <= 8'h01;
        end else if (wdt_reset) begin
            cause_reg <= 8'h02;
        end else if (in_sleep && wake_irq) begin
            cause_reg <= 8'h04;
        end
    end

    // Core-facing outputs, registered from the next state.
    always_ff @(posedge clk) begin
        if (rst) begin
            core_reset   <= 1'b1;
            core_asleep  <= 1'b0;
            osc_drive_en <= 1'b1;
            io_hold      <= 1'b0;
        end else begin
            core_reset   <= (state_next == WSW_ST_RESET) || (state_next == WSW_ST_PWRUP)
                          || (state_next == WSW_ST_OST);
            core_asleep  <= (state_next == WSW_ST_SLEEP);
            osc_drive_en <= (state_next != WSW_ST_SLEEP);
            io_hold      <= (state_next == WSW_ST_SLEEP);
        end
    end

    // Execution pulses around sleep and wake.
    always_ff @(posedge clk) begin
        if (rst) begin
            prefetch_next <= 1'b0;
            resume_exec   <= 1'b0;
            vector_branch <= 1'b0;
        end else begin
            prefetch_next <= in_run && sleep_instr && !reset_evt && !wdt_reset;
            resume_exec   <= (state_reg == WSW_ST_RESUME) && !reset_evt;
            vector_branch <= (state_reg == WSW_ST_RESUME) && !reset_evt
                           && !status_reg[`WSW_BIT_GLOBAL_IRQ_DISABLE];
        end
    end

    // Flag outputs follow the status register.
    always_ff @(posedge clk) begin
        if (rst) begin
            timeout_flag       <= 1'b1;
            powerdown_flag     <= 1'b1;
            global_irq_disable <= 1'b1;
        end else begin
            timeout_flag       <= status_reg[`WSW_BIT_TO];
            powerdown_flag     <= status_reg[`WSW_BIT_PD];
            global_irq_disable <= status_reg[`WSW_BIT_GLOBAL_IRQ_DISABLE];
        end
    end

    // Bus: waitrequest drops for one cycle after a request is seen.
    assign bus_wr = avs_write && !wait_reg;
    assign bus_rd = avs_read && !wait_reg;

    // Waitrequest toggles low for exactly the completing cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !((avs_read || avs_write) && wait_reg);
        end
    end

    // Read data captured with the waitrequest drop; unmapped reads zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && wait_reg) begin
            case (avs_address)
                `WSW_CPU_STATUS_IDX: avs_readdata <= {24'h00_0000, status_reg};
                `WSW_WAKE_CAUSE_IDX: avs_readdata <= {24'h00_0000, cause_reg};
                default:             avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_waitrequest = wait_reg;

endmodule : wsw_watchdog_sleep_wake

// ### wsw_asserts.sv
/* Port checker for the watchdog sleep/wake block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
module wsw_asserts (
    input wire logic                 clk,                // Clock.
    input wire logic                 rst,                // Reset.
    input wire logic                 avs_read,           // Read.
    input wire logic                 avs_write,          // Write.
    input wire logic                 avs_waitrequest,    // Stall.
    input wire wsw_pkg::wsw_cfg_type cfg,                // Config.
    input wire logic                 master_clear_pin_n, // Clear.
    input wire logic                 sleep_instr,        // Sleep.
    input wire wsw_pkg::wsw_wake_type wake_src,          // Wakes.
    input wire logic                 core_reset,         // Reset out.
    input wire logic                 core_asleep,        // Asleep.
    input wire logic                 osc_drive_en,       // Osc on.
    input wire logic                 io_hold,            // Pin hold.
    input wire logic                 prefetch_next,      // Prefetch.
    input wire logic                 resume_exec,        // Resume.
    input wire logic                 vector_branch,      // Branch.
    input wire logic                 timeout_flag,       // Timeout.
    input wire logic                 powerdown_flag,     // Powerdown.
    input wire logic                 global_irq_disable  // Disable.
);
    import wsw_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Sleep is taken only while the core runs.
    wire run = !core_reset && !core_asleep && sleep_instr;
    a_sleep_flags: assert property (run |-> ##2 (!powerdown_flag && timeout_flag))
        else $error("flags wrong after sleep");
    a_sleep_fetch: assert property (run |-> ##[1:2] prefetch_next)
        else $error("no prefetch after sleep");
    a_sleep_enter: assert property (run && wake_src == '0 |-> ##[1:2] core_asleep)
        else $error("sleep not entered");
    a_asleep_pins: assert property (core_asleep |-> !osc_drive_en && io_hold)
        else $error("oscillator or pins wrong asleep");
    a_branch_pair: assert property (vector_branch |-> resume_exec)
        else $error("branch without resume");
    a_resume_gate: assert property (resume_exec |-> vector_branch == !global_irq_disable)
        else $error("branch ignores global disable");
    a_other_stays: assert property (core_asleep && wake_src[9:1] == '0 && master_clear_pin_n
        |=> core_asleep || core_reset)
        else $error("woke without a source");
    a_wake_fast: assert property (core_asleep && |wake_src[9:1] && cfg.osc_mode == 2'h1
        |-> ##[1:3] resume_exec)
        else $error("wake too slow");
    a_timer_quiet: assert property (cfg.postscale == 2'h0 && $fell(timeout_flag) |-> !core_reset)
        else $error("timer overflow reset device");
    a_mclr_reset: assert property (!master_clear_pin_n |-> ##[0:2] core_reset)
        else $error("master clear ignored");
    a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    c_branch: cover property (resume_exec && vector_branch);
    c_timer: cover property (cfg.postscale == 2'h0 && $fell(timeout_flag));
    c_wdt: cover property (cfg.postscale == 2'h3 && $rose(core_reset));
endmodule : wsw_asserts

bind wsw_watchdog_sleep_wake wsw_asserts chk_u (.clk, .rst, .avs_read, .avs_write,
    .avs_waitrequest, .cfg, .master_clear_pin_n, .sleep_instr, .wake_src, .core_reset,
    .core_asleep, .osc_drive_en, .io_hold, .prefetch_next, .resume_exec, .vector_branch,
    .timeout_flag, .powerdown_flag, .global_irq_disable);

// ### wsw_core_model.sv
/* Core model issuing sleep and clear instruction pulses.
   Assumes one-cycle requests from the bench. */
`timescale 1ns/10ps
module wsw_core_model (
    input  wire logic clk,          // Clock.
    input  wire logic go_sleep,     // Sleep request.
    input  wire logic go_clear,     // Clear request.
    input  wire logic core_reset,   // Core in reset.
    input  wire logic core_asleep,  // Core asleep.
    output logic      sleep_instr,  // Sleep pulse.
    output logic      clear_instr   // Clear pulse.
);
    // Instructions only execute while the core runs.
    always_ff @(posedge clk) begin
        sleep_instr <= go_sleep && !core_reset && !core_asleep;
        clear_instr <= go_clear && !core_reset && !core_asleep;
    end
endmodule : wsw_core_model

// ### wsw_watchdog_sleep_wake_bench.sv
/* Self-checking bench for the watchdog sleep/wake block.
   Assumes the checker and core model are compiled. */
`timescale 1ns/10ps
module wsw_watchdog_sleep_wake_bench;
    import wsw_pkg::*;
    logic clk = 0, rst = 1, rd = 0, wr = 0, tk = 0, mc_n = 1, go_s = 0, go_c = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, q, rdat;
    logic wt, cr, sl, od, ioh, pf, rx, vb, to, pd, gd, si, ci;
    wsw_cfg_type cfg = 4'h9;
    wsw_wake_type ws = '0;
    int mismatches = 0, n_tests = 0, n;
    always #2.5 clk = ~clk;
    // Watchdog oscillator ticks every other clock.
    always @(posedge clk) tk <= ~tk;
    wsw_watchdog_sleep_wake #(.TIMER_OVF_CYCLES(16)) dut_u (.clk(clk), .rst(rst),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdat), .avs_waitrequest(wt), .cfg(cfg), .por_event(1'b0),
        .brownout_reset(1'b0), .master_clear_pin_n(mc_n), .wdt_rc_tick(tk),
        .sleep_instr(si), .watchdog_clear_instr(ci), .stack_avail(1'b1), .wake_src(ws),
        .core_reset(cr), .core_asleep(sl), .osc_drive_en(od), .io_hold(ioh),
        .prefetch_next(pf), .resume_exec(rx), .vector_branch(vb), .timeout_flag(to),
        .powerdown_flag(pd), .global_irq_disable(gd));
    wsw_core_model core_u (.clk(clk), .go_sleep(go_s), .go_clear(go_c), .core_reset(cr),
        .core_asleep(sl), .sleep_instr(si), .clear_instr(ci));
    task automatic step(input int k);
        repeat (k) @(posedge clk);
    endtask : step
    // One bus transfer, held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        @(posedge clk);
        for (n = 0; n < 20 && wt !== 1'b0; n++) @(posedge clk);
        q = rdat;
        rd <= 0;
        wr <= 0;
        @(posedge clk);
    endtask : bus
    task automatic req(input logic s);
        if (s) go_s <= 1;
        else go_c <= 1;
        step(1);
        go_s <= 0;
        go_c <= 0;
    endtask : req
    task automatic wait_rx(input int lim);
        for (n = 0; n < lim && rx !== 1'b1; n++) @(posedge clk);
    endtask : wait_rx
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    initial begin : watchdog
        #100000;
        mismatches++;
        summarize();
    end
    initial begin : main
        step(3);
        rst <= 0;
        for (n = 0; n < 400 && cr !== 1'b0; n++) @(posedge clk);
        chk("reset release", 0, cr);
        bus(0, 4'h6, 0); chk("status", 32'h3c, q);
        bus(0, 4'h3, 0); chk("unmapped", 0, q);
        bus(1, 4'h6, 0); bus(0, 4'h6, 0); chk("status write", 32'h2c, q);
        req(1); step(3); chk("sleep", 5'b01101, {pd, to, sl, od, ioh});
        ws.other_periph <= 1; step(5); chk("no wake", 1, sl);
        ws.int_pin <= 1; wait_rx(10); chk("branch", 1, vb);
        ws <= '0;
        cfg.osc_mode <= 2'h2; step(2); req(1); step(3);
        ws.capture <= 1; wait_rx(3000); chk("start delay", 1, n > 1023);
        ws <= '0;
        cfg.osc_mode <= 2'h1; ws.adc_done <= 1; step(2); req(1);
        wait_rx(10); chk("pending", 1, n < 10 && pd === 1'b0);
        ws <= '0;
        cfg.postscale <= 2'h0; step(1); req(0);
        for (n = 0; n < 100 && to !== 1'b0; n++) @(posedge clk);
        chk("timer", 2'b10, {n < 100, cr});
        req(0); step(3); chk("timer clear", 1, to);
        cfg.postscale <= 2'h3; req(0);
        for (n = 0; n < 200 && cr !== 1'b1; n++) @(posedge clk);
        chk("wdt reset", 1, n < 200);
        for (n = 0; n < 100 && cr !== 1'b0; n++) @(posedge clk);
        bus(0, 4'h6, 0); chk("wdt flags", 32'h0, q & 32'hc);
        cfg.postscale <= 2'h2; mc_n <= 0; step(2); chk("mclr", 1, cr);
        mc_n <= 1;
        summarize();
    end
endmodule : wsw_watchdog_sleep_wake_bench
